// ==== rtl/gsw_map.svh ====
// Register offsets, field positions and reset values of the gateway status word block
`ifndef GSW_MAP_SVH
`define GSW_MAP_SVH

// ****************************************************************
// Register offsets (word addresses on the plain port)
// ****************************************************************
`define GSW_ADDR_STATUS0   4'h0
`define GSW_ADDR_CTRL0     4'h1
`define GSW_ADDR_CTRL1     4'h2
`define GSW_ADDR_CONFIG    4'h3
`define GSW_ADDR_FAULT     4'h4
`define GSW_ADDR_IRQSTAT   4'h5
`define GSW_ADDR_IRQMASK   4'h6

// ****************************************************************
// Status word field positions
// ****************************************************************
`define GSW_BIT_RUN        15
`define GSW_BIT_HELD       14
`define GSW_BIT_LINK       13
`define GSW_BIT_SELECTOR   12
`define GSW_BIT_HEAVY      11
`define GSW_BIT_LIGHT      10
`define GSW_BIT_UNUSED     9
`define GSW_BIT_ESTOP      8
`define GSW_CODE_MSB       7

// ****************************************************************
// Control word 0 and configuration fields
// ****************************************************************
`define GSW_CTRL0_CANCEL   13
`define GSW_CFG_LATCH      0

// ****************************************************************
// Fault register fields (software raised gateway faults)
// ****************************************************************
`define GSW_FLT_HEAVY      8
`define GSW_FLT_LIGHT      9

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define GSW_IRQ_LINK       0
`define GSW_IRQ_HEAVY      1
`define GSW_IRQ_LIGHT      2
`define GSW_IRQ_ESTOP      3
`define GSW_IRQ_WIDTH      4

// ****************************************************************
// Reset values
// ****************************************************************
`define GSW_RST_WORD       16'h0000
`define GSW_RST_CONFIG     16'h0000
`define GSW_RST_IRQ        4'h0

`endif

// ==== rtl/gsw_pkg.sv ====
// Types shared by the gateway status word block
package gsw_pkg;

    typedef enum logic [1:0] {
        GSW_BOOT,
        GSW_RUNNING,
        GSW_HALTED
    } gsw_mode_e;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } gsw_bus_s;

    typedef struct packed {
        logic        linkFault;
        logic        selectorHand;
        logic        estopInputN;
        logic        gatewayReady;
    } gsw_field_s;

endpackage : gsw_pkg

// ==== rtl/gsw_held_latch.sv ====
// Held link fault latch with configuration gate and cancel
`timescale 1ns/1ps
`include "gsw_map.svh"

module gsw_held_latch (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic latchEnable,
    input  wire logic faultSeen,
    input  wire logic cancelReq,
    output logic      heldFlag
);

    typedef struct packed {
        logic held;
    } gsw_latch_s;

    gsw_latch_s state_ff;
    gsw_latch_s nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (!latchEnable) begin
            nxt_state.held = 1'b0;
        end else if (faultSeen) begin
            nxt_state.held = 1'b1;
        end else if (cancelReq) begin
            nxt_state.held = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign heldFlag = state_ff.held;

endmodule : gsw_held_latch

// ==== rtl/gsw_status_word.sv ====
// Gateway status word register bank with PLC control words and interrupt
`timescale 1ns/1ps
`include "gsw_map.svh"

module gsw_status_word (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire gsw_pkg::gsw_bus_s   bus,
    output logic [15:0]              rdata,
    input  wire gsw_pkg::gsw_field_s field,
    output logic [15:0]              statusWord,
    output logic                     axisEstop,
    output logic                     irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        gsw_pkg::gsw_mode_e        mode;
        logic [15:0]               rdata;
        logic [15:0]               status;
        logic [15:0]               ctrl0;
        logic                      latchCfg;
        logic                      heavy;
        logic                      light;
        logic [7:0]                code;
        logic [`GSW_IRQ_WIDTH-1:0] irqStat;
        logic [`GSW_IRQ_WIDTH-1:0] irqMask;
        logic [`GSW_IRQ_WIDTH-1:0] evPrev;
        logic                      estop;
        logic                      irq;
    } gsw_state_s;

    gsw_state_s state_ff;
    gsw_state_s nxt_state;

    logic                      heldFlag;
    logic                      cancelReq;
    logic [`GSW_IRQ_WIDTH-1:0] evNow;
    logic [`GSW_IRQ_WIDTH-1:0] evRise;
    logic [15:0]               word;

    // ****************************************************************
    // Held fault latch
    // ****************************************************************
    // cancel comes from the PLC control word
    assign cancelReq = state_ff.ctrl0[`GSW_CTRL0_CANCEL];

    gsw_held_latch u_latch (
        .core_clk    (core_clk),
        .reset       (reset),
        .latchEnable (state_ff.latchCfg),
        .faultSeen   (field.linkFault),
        .cancelReq   (cancelReq),
        .heldFlag    (heldFlag)
    );

    // ****************************************************************
    // Status word assembly
    // ****************************************************************
    always_comb begin
        word = `GSW_RST_WORD;
        word[`GSW_BIT_RUN] = (state_ff.mode == gsw_pkg::GSW_RUNNING);
        word[`GSW_BIT_HELD] = heldFlag;
        word[`GSW_BIT_LINK] = field.linkFault;
        word[`GSW_BIT_SELECTOR] = field.selectorHand;
        word[`GSW_BIT_HEAVY] = state_ff.heavy;
        word[`GSW_BIT_LIGHT] = state_ff.light;
        word[`GSW_BIT_UNUSED] = 1'b0;
        word[`GSW_BIT_ESTOP] = !field.estopInputN;
        word[`GSW_CODE_MSB:0] = state_ff.code;
    end

    assign evNow = {!field.estopInputN, state_ff.light, state_ff.heavy, field.linkFault};
    assign evRise = evNow & ~state_ff.evPrev;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.status = word;
        nxt_state.evPrev = evNow;
        nxt_state.rdata = 16'h0000;

        // Mode: heavy fault halts until reset, restart is the only way out
        case (state_ff.mode)
            gsw_pkg::GSW_BOOT: begin
                if (field.gatewayReady) begin
                    nxt_state.mode = gsw_pkg::GSW_RUNNING;
                end
            end
            gsw_pkg::GSW_RUNNING: begin
                if (state_ff.heavy || !field.gatewayReady) begin
                    nxt_state.mode = state_ff.heavy ? gsw_pkg::GSW_HALTED
                                                    : gsw_pkg::GSW_BOOT;
                end
            end
            gsw_pkg::GSW_HALTED: begin
                nxt_state.mode = gsw_pkg::GSW_HALTED;
            end
            default: begin
                nxt_state.mode = gsw_pkg::GSW_BOOT;
            end
        endcase

        // all axes stop while the flag is set
        nxt_state.estop = word[`GSW_BIT_ESTOP];

        if (bus.wr) begin
            case (bus.addr)
                `GSW_ADDR_CTRL0: begin
                    nxt_state.ctrl0 = bus.wdata;
                end
                `GSW_ADDR_CONFIG: begin
                    nxt_state.latchCfg = bus.wdata[`GSW_CFG_LATCH];
                end
                `GSW_ADDR_FAULT: begin
                    nxt_state.code = bus.wdata[`GSW_CODE_MSB:0];
                    nxt_state.heavy = state_ff.heavy | bus.wdata[`GSW_FLT_HEAVY];
                    nxt_state.light = bus.wdata[`GSW_FLT_LIGHT];
                end
                `GSW_ADDR_IRQSTAT: begin
                    nxt_state.irqStat = state_ff.irqStat & ~bus.wdata[`GSW_IRQ_WIDTH-1:0];
                end
                `GSW_ADDR_IRQMASK: begin
                    nxt_state.irqMask = bus.wdata[`GSW_IRQ_WIDTH-1:0];
                end
                // control word 1 writes are dropped
                default: begin
                    nxt_state.ctrl0 = state_ff.ctrl0;
                end
            endcase
        end

        // New events win over a clear in the same cycle
        nxt_state.irqStat = nxt_state.irqStat | evRise;
        nxt_state.irq = |(nxt_state.irqStat & nxt_state.irqMask);

        if (bus.rd) begin
            case (bus.addr)
                `GSW_ADDR_STATUS0: nxt_state.rdata = word;
                `GSW_ADDR_CTRL0:   nxt_state.rdata = state_ff.ctrl0;
                `GSW_ADDR_CTRL1:   nxt_state.rdata = 16'h0000;
                `GSW_ADDR_CONFIG:  nxt_state.rdata = {15'h0000, state_ff.latchCfg};
                `GSW_ADDR_FAULT: begin
                    nxt_state.rdata = {6'h00, state_ff.light, state_ff.heavy,
                                       state_ff.code};
                end
                `GSW_ADDR_IRQSTAT: nxt_state.rdata = {12'h000, state_ff.irqStat};
                `GSW_ADDR_IRQMASK: nxt_state.rdata = {12'h000, state_ff.irqMask};
                default:           nxt_state.rdata = 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff          <= '0;
            state_ff.mode     <= gsw_pkg::GSW_BOOT;
            state_ff.status   <= `GSW_RST_WORD;
            state_ff.ctrl0    <= `GSW_RST_WORD;
            state_ff.latchCfg <= 1'b0;
            state_ff.irqStat  <= `GSW_RST_IRQ;
            state_ff.irqMask  <= `GSW_RST_IRQ;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata      = state_ff.rdata;
    assign statusWord = state_ff.status;
    assign axisEstop  = state_ff.estop;
    assign irq        = state_ff.irq;

endmodule : gsw_status_word

// ==== verif/gsw_status_word_properties.sv ====
// Concurrent checks on the gateway status word ports
`timescale 1ns/1ps
`include "gsw_map.svh"

module gsw_status_word_properties (
    input wire logic               core_clk,
    input wire logic               reset,
    input wire gsw_pkg::gsw_bus_s   bus,
    input wire logic [15:0]        rdata,
    input wire gsw_pkg::gsw_field_s field,
    input wire logic [15:0]        statusWord,
    input wire logic               axisEstop,
    input wire logic               irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // First edge after release still sees reset in its history
    sequence live;
        !$past(reset);
    endsequence
    sequence faultWr;
        bus.wr && bus.addr == `GSW_ADDR_FAULT;
    endsequence
    sequence notReady;
        !field.gatewayReady ##1 !field.gatewayReady;
    endsequence

    estop_bit_a: assert property (live |-> statusWord[8] == !$past(field.estopInputN))
        else $error("stop flag does not follow input");
    axis_stop_a: assert property (live |-> axisEstop == !$past(field.estopInputN))
        else $error("axis stop does not follow input");
    selector_bit_a: assert property (live |-> statusWord[12] == $past(field.selectorHand))
        else $error("selector flag wrong");
    link_bit_a: assert property (live |-> statusWord[13] == $past(field.linkFault))
        else $error("link fault flag wrong");
    unused_bit_a: assert property (statusWord[9] == 1'b0)
        else $error("unused bit set");
    read_idle_a: assert property (live ##0 !$past(bus.rd) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    ctrl_one_a: assert property ($past(bus.rd) && $past(bus.addr) == 4'h2 |-> !rdata)
        else $error("second control word not zero");
    stopped_run_a: assert property (notReady |=> !statusWord[15])
        else $error("run flag while not ready");
    fault_code_a: assert property (faultWr |-> ##2 statusWord[7:0] == $past(bus.wdata[7:0], 2))
        else $error("fault code not shown");
    heavy_flag_a: assert property (faultWr ##0 bus.wdata[8] |-> ##2 statusWord[11])
        else $error("heavy fault not shown");
endmodule : gsw_status_word_properties

bind gsw_status_word gsw_status_word_properties i_props (
    .core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata), .field(field),
    .statusWord(statusWord), .axisEstop(axisEstop), .irq(irq));

// ==== verif/gsw_plc_model.sv ====
// Fieldbus master model reaching the gateway registers
`timescale 1ns/1ps

module gsw_plc_model (
    input  wire logic        core_clk,
    output gsw_pkg::gsw_bus_s bus,
    input  wire logic [15:0] rdata
);
    initial bus = '0;

    // one write strobe to address a with data d, then wr drops
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
endmodule : gsw_plc_model

// ==== verif/gsw_status_word_tb_top.sv ====
// Self-checking bench for the gateway status word
`timescale 1ns/1ps
`include "gsw_map.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin errCount++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end

module gsw_status_word_tb_top;
    logic               core_clk;
    logic               reset;
    gsw_pkg::gsw_bus_s   bus;
    gsw_pkg::gsw_field_s field;
    logic [15:0]        rdata;
    logic [15:0]        statusWord;
    logic               axisEstop;
    logic               irq;
    logic [15:0]        d;
    logic [31:0]        rngState = 32'h192ee187;
    int                 errCount = 0;
    int                 comparisons = 0;

    gsw_status_word i_dut (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata),
        .field(field), .statusWord(statusWord), .axisEstop(axisEstop), .irq(irq));
    gsw_plc_model i_plc (.core_clk(core_clk), .bus(bus), .rdata(rdata));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [15:0] expLive(input gsw_pkg::gsw_field_s f);
        return {2'b00, f.linkFault, f.selectorHand, 3'b000, !f.estopInputN, 8'h00};
    endfunction : expLive

    task automatic endOfTest();
        $display("errors %0d comparisons %0d", errCount, comparisons);
        if (errCount == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : endOfTest

    task automatic waitCk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : waitCk

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        field = '{1'b0, 1'b0, 1'b1, 1'b0};
        reset = 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("reset word", 16'h0000, statusWord)
        reset <= 1'b0;
        i_plc.rd(`GSW_ADDR_CONFIG, d);
        `CHK("config reset", 16'h0000, d)
        repeat (40) begin
            rngState = xorshift(rngState);
            @(posedge core_clk);
            field <= '{rngState[0], rngState[1], rngState[2], 1'b0};
            waitCk(2);
            `CHK("live bits", expLive(field), statusWord & 16'h3300)
            `CHK("axis stop", !field.estopInputN, axisEstop)
        end
        for (int i = 0; i < 8; i++) begin
            i_plc.wr(`GSW_ADDR_FAULT, {6'h00, i[0], 1'b0, 8'h01 << i});
            waitCk(2);
            `CHK("code", 8'h01 << i, statusWord[7:0])
            `CHK("light", i[0], statusWord[10])
        end
        field <= '{1'b0, 1'b0, 1'b1, 1'b1};
        waitCk(4);
        `CHK("run", 1'b1, statusWord[15])
        field.gatewayReady <= 1'b0;
        waitCk(4);
        `CHK("not run", 1'b0, statusWord[15])
        field.gatewayReady <= 1'b1;
        // Held fault outlives a one cycle link glitch only while the latch is configured
        for (int c = 1; c >= 0; c--) begin
            i_plc.wr(`GSW_ADDR_CONFIG, 16'(c));
            field.linkFault <= 1'b1;
            @(posedge core_clk);
            field.linkFault <= 1'b0;
            waitCk(4);
            `CHK("held", c[0], statusWord[14])
            i_plc.wr(`GSW_ADDR_CTRL0, 16'h2000);
            waitCk(3);
            `CHK("cancelled", 1'b0, statusWord[14])
            i_plc.wr(`GSW_ADDR_CTRL0, 16'h0000);
        end
        i_plc.wr(`GSW_ADDR_CTRL1, 16'hffff);
        i_plc.rd(`GSW_ADDR_CTRL1, d);
        `CHK("ctrl1 read", 16'h0000, d)
        i_plc.rd(4'hf, d);
        `CHK("unmapped", 16'h0000, d)
        // Stale events from the random phase would hide a missing estop event
        i_plc.wr(`GSW_ADDR_IRQSTAT, 16'h000f);
        i_plc.wr(`GSW_ADDR_IRQMASK, 16'h0008);
        waitCk(1);
        `CHK("irq idle", 1'b0, irq)
        field.estopInputN <= 1'b0;
        waitCk(3);
        `CHK("irq up", 1'b1, irq)
        field.estopInputN <= 1'b1;
        i_plc.wr(`GSW_ADDR_IRQSTAT, 16'h000f);
        waitCk(2);
        `CHK("irq clear", 1'b0, irq)
        i_plc.wr(`GSW_ADDR_IRQMASK, 16'h0000);
        field.estopInputN <= 1'b0;
        waitCk(3);
        `CHK("irq masked", 1'b0, irq)
        i_plc.rd(`GSW_ADDR_IRQSTAT, d);
        `CHK("irq status", 1'b1, d[`GSW_IRQ_ESTOP])
        i_plc.wr(`GSW_ADDR_FAULT, 16'h0100);
        i_plc.wr(`GSW_ADDR_FAULT, 16'h0000);
        waitCk(3);
        // Heavy fault stays until restart and halts running
        `CHK("heavy", 1'b1, statusWord[11])
        `CHK("halted", 1'b0, statusWord[15])
        // A restart is the only way out of a heavy fault
        reset <= 1'b1;
        waitCk(2);
        reset <= 1'b0;
        waitCk(3);
        `CHK("restart heavy", 1'b0, statusWord[11])
        `CHK("restart run", 1'b1, statusWord[15])
        endOfTest();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        errCount++;
        endOfTest();
    end
endmodule : gsw_status_word_tb_top
